/* pkg/spc_consts.svh */
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// ==========================================================
// link constants
`define SPC_SYNC_WORD    32'h7EAA997E
`define SPC_DUMMY_BITS   49
`define SPC_RST_HOLD_NS  200
`define SPC_SCK_MIN_NS   40
`define SPC_SCK_MAX_NS   1000
`define SPC_CLK_NS       100
`define SPC_RST_WAIT_US  1000
`define SPC_IMAGE_BITS   64
`define SPC_SHUT_LEN     1
`define SPC_SHUT_BYTE    8'h00
`define SPC_DONE_WAIT    16
`define SPC_SCK_HALF     1
`define SPC_IDLE_BYTE    8'hFF

`endif

/* pkg/spc_pkg.sv */
// ==========================================================
// shared types
package spc_pkg;

	// host sequencer, gray along the load path
	typedef enum logic [2:0] {
		H_IDLE  = 3'h0,
		H_RST   = 3'h1,
		H_WAIT  = 3'h3,
		H_SHUT  = 3'h2,
		H_IMAGE = 3'h6,
		H_TAIL  = 3'h7,
		H_END   = 3'h5
	} spc_host_state_type;

endpackage : spc_pkg

/* pkg/spc_link_if.sv */
`timescale 1ns/10ps

// ==========================================================
// serial load link between processor and device
interface spc_link_if;
	logic rst_drv;        // open-drain reset, level when driven
	logic rst_oe_n;       // low while the host pulls reset
	logic ss_n;
	logic sck;
	logic sdi;
	logic done_drv;       // open-drain done, level when driven
	logic done_oe_n;      // low while the device pulls done
	logic sdo_drv;
	logic sdo_oe_n;
	logic config_reset_n;
	logic config_done;
	logic sdo;

	// pull-ups resolve the open-drain lines
	assign config_reset_n = rst_oe_n ? 1'b1 : rst_drv;
	assign config_done    = done_oe_n ? 1'b1 : done_drv;
	assign sdo            = sdo_oe_n ? 1'b0 : sdo_drv;

	modport dev (
		input  config_reset_n, ss_n, sck, sdi,
		output done_drv, done_oe_n, sdo_drv, sdo_oe_n
	);
	modport host (
		output rst_drv, rst_oe_n, ss_n, sck, sdi,
		input  config_done, sdo
	);
endinterface : spc_link_if

/* core/spc_device.sv */
`timescale 1ns/10ps
`include "spc_consts.svh"

module spc_device import spc_pkg::*; #(
	parameter int IMAGE_BITS = `SPC_IMAGE_BITS
) (
	// system side
	input  wire logic  clock,
	input  wire logic  sys_rst,
	// link
	spc_link_if.dev    link,
	// user side
	output logic       periph_mode,
	output logic       image_loaded,
	output logic       user_io_en
);

	// ==========================================================
	// link clock domain, cleared while config reset is low
	logic        mode_m_reg, mode_k_reg;
	logic [31:0] sh_reg, sh_next;
	logic        synced_reg, synced_next;
	logic [31:0] cnt_reg, cnt_next;
	logic        done_reg, done_next;
	logic [5:0]  dum_reg, dum_next;
	logic        rel_reg, rel_next;
	logic        mode_reg;
	logic [31:0] sh_in;

	// shift, hunt for sync word, count image then dummy bits
	always_comb begin
		sh_in       = {sh_reg[30:0], link.sdi};
		sh_next     = sh_reg;
		synced_next = synced_reg;
		cnt_next    = cnt_reg;
		done_next   = done_reg;
		dum_next    = dum_reg;
		rel_next    = rel_reg;
		if (mode_k_reg && !link.ss_n) begin
			if (!synced_reg) begin
				sh_next = sh_in;
				if (sh_in == `SPC_SYNC_WORD) begin
					synced_next = 1'b1;
					cnt_next    = 32'h0;
				end
			end else if (!done_reg) begin
				cnt_next = cnt_reg + 32'h1;
				if (cnt_reg == 32'(IMAGE_BITS - 1)) begin
					done_next = 1'b1;
				end
			end else if (!rel_reg) begin
				dum_next = dum_reg + 6'h1;
				if (dum_reg == 6'(`SPC_DUMMY_BITS - 1)) begin
					rel_next = 1'b1;
				end
			end
		end
	end

	// rising sck samples data; low reset drops any load in flight
	always_ff @(posedge link.sck or negedge link.config_reset_n) begin
		if (!link.config_reset_n) begin
			mode_m_reg <= 1'b0;
			mode_k_reg <= 1'b0;
			sh_reg     <= 32'h0;
			synced_reg <= 1'b0;
			cnt_reg    <= 32'h0;
			done_reg   <= 1'b0;
			dum_reg    <= 6'h0;
			rel_reg    <= 1'b0;
		end else begin
			mode_m_reg <= mode_reg;
			mode_k_reg <= mode_m_reg;
			sh_reg     <= sh_next;
			synced_reg <= synced_next;
			cnt_reg    <= cnt_next;
			done_reg   <= done_next;
			dum_reg    <= dum_next;
			rel_reg    <= rel_next;
		end
	end

	// done pulled low until the image is in, then left to the pull-up
	assign link.done_drv  = 1'b0;
	assign link.done_oe_n = done_reg;
	// serial output stays undriven during a load
	assign link.sdo_drv   = 1'b0;
	assign link.sdo_oe_n  = 1'b1;

	// ==========================================================
	// system clock domain: mode strap and status
	logic rst_m_reg, rst_s_reg, rst_d_reg;
	logic ss_m_reg, ss_s_reg;
	logic mode_next;
	logic done_m_reg, done_s_reg, rel_m_reg, rel_s_reg;

	// strap caught on the synchronised rise of config reset
	always_comb begin
		mode_next = mode_reg;
		if (!rst_s_reg) begin
			mode_next = 1'b0;
		end else if (!rst_d_reg && !ss_s_reg) begin
			mode_next = 1'b1;
		end
	end

	// both strap pins use equal depth so they stay aligned
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rst_m_reg  <= 1'b0;
			rst_s_reg  <= 1'b0;
			rst_d_reg  <= 1'b0;
			ss_m_reg   <= 1'b1;
			ss_s_reg   <= 1'b1;
			mode_reg   <= 1'b0;
			done_m_reg <= 1'b0;
			done_s_reg <= 1'b0;
			rel_m_reg  <= 1'b0;
			rel_s_reg  <= 1'b0;
		end else begin
			rst_m_reg  <= link.config_reset_n;
			rst_s_reg  <= rst_m_reg;
			rst_d_reg  <= rst_s_reg;
			ss_m_reg   <= link.ss_n;
			ss_s_reg   <= ss_m_reg;
			mode_reg   <= mode_next;
			done_m_reg <= done_reg;
			done_s_reg <= done_m_reg;
			rel_m_reg  <= rel_reg;
			rel_s_reg  <= rel_m_reg;
		end
	end

	assign periph_mode  = mode_reg;
	assign image_loaded = done_s_reg;
	assign user_io_en   = rel_s_reg;

endmodule : spc_device

/* core/spc_host.sv */
`timescale 1ns/10ps
`include "spc_consts.svh"

// Contract
// - device discards load while reset low
// - host holds reset low at least 200 ns
// - reset rising with select low picks peripheral mode
// - host waits reset-to-clock time before data
// - bytes go out most significant bit first
// - host changes data on falling clock
// - device samples data on rising clock
// - clock 1 to 25 MHz after sync
// - image sent as one unbroken stream
// - image must not enable boot selection options
// - send memory shut-off sequence before image
// - device releases done after full image
// - done still low means failed load
// - host sends 49 dummy clocks after done
// - device frees port pins after dummy clocks
// - device serial output unused during load
// - reload by pulsing reset, repeat sequence
module spc_host import spc_pkg::*; #(
	parameter int         SCK_HALF  = `SPC_SCK_HALF,
	parameter int         WAIT_CYC  = `SPC_RST_WAIT_US * 1000 / `SPC_CLK_NS,
	parameter int         SHUT_LEN  = `SPC_SHUT_LEN,
	parameter logic [7:0] SHUT_BYTE = `SPC_SHUT_BYTE,
	parameter int         DONE_WAIT = `SPC_DONE_WAIT
) (
	// system side
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// link
	spc_link_if.host         link,
	// load command
	input  wire logic        start,
	// image byte stream
	input  wire logic [7:0]  img_data,
	input  wire logic        img_valid,
	input  wire logic        img_last,
	output logic             img_ready,
	// status
	output logic             busy,
	output logic             load_ok,
	output logic             load_fail
);

	// ==========================================================
	// timing derived from the system clock
	localparam int RST_HOLD_CYC = (`SPC_RST_HOLD_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS;
	localparam int SCK_PER_NS   = 2 * SCK_HALF * `SPC_CLK_NS;

	// the divider must keep the clock in its legal band
	localparam bit SCK_LEGAL = (SCK_PER_NS >= `SPC_SCK_MIN_NS) && (SCK_PER_NS <= `SPC_SCK_MAX_NS);
	if (!SCK_LEGAL) begin : g_bad_sck
		$error("link clock divider out of range");
	end

	// ==========================================================
	// state
	spc_host_state_type state_reg, state_next;
	logic [31:0] tmr_reg, tmr_next;
	logic [7:0]  half_reg, half_next;
	logic        sck_reg, sck_next;
	logic        sdi_reg, sdi_next;
	logic        ss_n_reg, ss_n_next;
	logic        rst_oe_n_reg, rst_oe_n_next;
	logic [7:0]  sh_reg, sh_next;
	logic [2:0]  bit_reg, bit_next;
	logic [7:0]  cnt_reg, cnt_next;
	logic        seen_reg, seen_next;
	logic        last_reg, last_next;
	logic        ok_reg, ok_next;
	logic        fail_reg, fail_next;
	logic        done_m_reg, done_s_reg;
	logic        tick;
	logic        need_img;

	// ==========================================================
	// sequencer: reset pulse, wait, shut-off, image, dummy tail
	always_comb begin
		state_next    = state_reg;
		tmr_next      = tmr_reg;
		half_next     = half_reg;
		sck_next      = sck_reg;
		sdi_next      = sdi_reg;
		ss_n_next     = ss_n_reg;
		rst_oe_n_next = rst_oe_n_reg;
		sh_next       = sh_reg;
		bit_next      = bit_reg;
		cnt_next      = cnt_reg;
		seen_next     = seen_reg;
		last_next     = last_reg;
		ok_next       = ok_reg;
		fail_next     = fail_reg;
		img_ready     = 1'b0;
		need_img      = 1'b0;
		tick          = (half_reg == 8'(SCK_HALF - 1));
		case (state_reg)
			H_IDLE, H_END: begin
				sck_next  = 1'b0;
				ss_n_next = 1'b1;
				if (start) begin
					state_next    = H_RST;
					tmr_next      = 32'h0;
					rst_oe_n_next = 1'b0;
					ss_n_next     = 1'b0;
					ok_next       = 1'b0;
					fail_next     = 1'b0;
					seen_next     = 1'b0;
					last_next     = 1'b0;
				end
			end
			H_RST: begin
				tmr_next = tmr_reg + 32'h1;
				if (tmr_reg == 32'(RST_HOLD_CYC - 1)) begin
					rst_oe_n_next = 1'b1;
					tmr_next      = 32'h0;
					state_next    = H_WAIT;
				end
			end
			H_WAIT: begin
				tmr_next = tmr_reg + 32'h1;
				if (tmr_reg == 32'(WAIT_CYC - 1)) begin
					state_next = H_SHUT;
					sh_next    = SHUT_BYTE;
					sdi_next   = SHUT_BYTE[7];
					bit_next   = 3'h0;
					cnt_next   = 8'h0;
					half_next  = 8'h0;
					sck_next   = 1'b0;
				end
			end
			H_SHUT, H_IMAGE, H_TAIL: begin
				half_next = tick ? 8'h0 : half_reg + 8'h1;
				// rising edge: the device samples here
				if (tick && !sck_reg) begin
					sck_next = 1'b1;
					if (state_reg == H_TAIL) begin
						if (seen_reg) begin
							cnt_next = cnt_reg + 8'h1;
							if (cnt_reg == 8'(`SPC_DUMMY_BITS - 1)) begin
								ok_next    = 1'b1;
								state_next = H_END;
							end
						end else if (done_s_reg) begin
							seen_next = 1'b1;
							cnt_next  = 8'h0;
						end else begin
							cnt_next = cnt_reg + 8'h1;
							if (cnt_reg == 8'(DONE_WAIT - 1)) begin
								fail_next  = 1'b1;
								state_next = H_END;
							end
						end
					end
				end
				// falling edge: next bit goes out
				if (tick && sck_reg) begin
					sck_next = 1'b0;
					bit_next = bit_reg + 3'h1;
					if (bit_reg == 3'h7) begin
						case (state_reg)
							H_SHUT: begin
								cnt_next = cnt_reg + 8'h1;
								if (cnt_reg == 8'(SHUT_LEN - 1)) begin
									need_img = 1'b1;
								end else begin
									sh_next  = SHUT_BYTE;
									sdi_next = SHUT_BYTE[7];
								end
							end
							H_IMAGE: begin
								if (last_reg) begin
									state_next = H_TAIL;
									sh_next    = `SPC_IDLE_BYTE;
									sdi_next   = 1'b1;
									cnt_next   = 8'h0;
								end else begin
									need_img = 1'b1;
								end
							end
							default: begin
								sh_next  = `SPC_IDLE_BYTE;
								sdi_next = 1'b1;
							end
						endcase
					end else begin
						sh_next  = {sh_reg[6:0], 1'b0};
						sdi_next = sh_reg[6];
					end
				end
				// a missing byte would break the stream, so the load is abandoned
				if (need_img) begin
					img_ready = 1'b1;
					if (img_valid) begin
						state_next = H_IMAGE;
						sh_next    = img_data;
						sdi_next   = img_data[7];
						last_next  = img_last;
					end else begin
						fail_next  = 1'b1;
						ss_n_next  = 1'b1; // a paused clock with select low would break the stream
						state_next = H_END;
					end
				end
			end
			default: begin
				state_next = H_IDLE;
			end
		endcase
	end

	// registers; done arrives from a pin, so two flops first
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg    <= H_IDLE;
			tmr_reg      <= 32'h0;
			half_reg     <= 8'h0;
			sck_reg      <= 1'b0;
			sdi_reg      <= 1'b0;
			ss_n_reg     <= 1'b1;
			rst_oe_n_reg <= 1'b1;
			sh_reg       <= 8'h0;
			bit_reg      <= 3'h0;
			cnt_reg      <= 8'h0;
			seen_reg     <= 1'b0;
			last_reg     <= 1'b0;
			ok_reg       <= 1'b0;
			fail_reg     <= 1'b0;
			done_m_reg   <= 1'b0;
			done_s_reg   <= 1'b0;
		end else begin
			state_reg    <= state_next;
			tmr_reg      <= tmr_next;
			half_reg     <= half_next;
			sck_reg      <= sck_next;
			sdi_reg      <= sdi_next;
			ss_n_reg     <= ss_n_next;
			rst_oe_n_reg <= rst_oe_n_next;
			sh_reg       <= sh_next;
			bit_reg      <= bit_next;
			cnt_reg      <= cnt_next;
			seen_reg     <= seen_next;
			last_reg     <= last_next;
			ok_reg       <= ok_next;
			fail_reg     <= fail_next;
			done_m_reg   <= link.config_done;
			done_s_reg   <= done_m_reg;
		end
	end

	// ==========================================================
	// outputs
	assign link.rst_drv  = 1'b0; // open-drain: only ever pulls low
	assign link.rst_oe_n = rst_oe_n_reg;
	assign link.ss_n     = ss_n_reg;
	assign link.sck      = sck_reg;
	assign link.sdi      = sdi_reg;
	assign busy          = (state_reg != H_IDLE) && (state_reg != H_END);
	assign load_ok       = ok_reg;
	assign load_fail     = fail_reg;

endmodule : spc_host

/* testbench/spc_link_monitor.sv */
`timescale 1ns/10ps
`include "spc_consts.svh"

// ==========================================================
// link checker, sees the wires between the two ends and the host reset enable rst_oe_n
module spc_link_monitor (
	// system domain
	input wire logic clock,
	input wire logic sys_rst,
	// link
	input wire logic config_reset_n,
	input wire logic rst_oe_n,
	input wire logic ss_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic config_done,
	input wire logic sdo
);
	logic [7:0] dummy_cnt;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// link clock rises seen with done high; saturates so a long tail cannot wrap
	always_ff @(posedge sck or negedge config_reset_n) begin
		if (!config_reset_n)
			dummy_cnt <= 8'h00;
		else if (config_done && dummy_cnt != 8'hFF)
			dummy_cnt <= dummy_cnt + 8'h01;
	end

	// ==========================================================
	// named steps of the load
	sequence s_rst_low;
		(!rst_oe_n) [*2];
	endsequence
	sequence s_quiet_clk;
		(!sck) [*8];
	endsequence

	AST_RST_HOLD: assert property ($fell(rst_oe_n) |-> s_rst_low)
		else $error("reset pulse shorter than two clocks");
	AST_MODE_SEL: assert property ($rose(config_reset_n) |-> !ss_n)
		else $error("reset released with select high");
	AST_CLR_WAIT: assert property ($rose(config_reset_n) |-> s_quiet_clk)
		else $error("link clock started too early");
	AST_DATA_SETUP: assert property ($rose(sck) |-> $stable(sdi))
		else $error("data changed with rising link clock");
	AST_SCK_HIGH: assert property ($rose(sck) |=> !sck)
		else $error("link clock high phase wrong");
	AST_SCK_LOW: assert property ($fell(sck) && !ss_n |=> sck || ss_n)
		else $error("link clock paused mid stream");
	AST_RST_DISCARD: assert property (!config_reset_n |=> !config_done)
		else $error("done high during reset");
	AST_DONE_HOLD: assert property ($fell(config_done) |-> !config_reset_n)
		else $error("done dropped without reset");
	AST_SDO_IDLE: assert property (!ss_n |-> !sdo)
		else $error("serial output active during load");
	AST_DUMMY: assert property ($rose(ss_n) && config_done |-> dummy_cnt >= 8'h31)
		else $error("fewer than 49 dummy clocks");
endmodule : spc_link_monitor

/* testbench/testbench.sv */
`timescale 1ns/10ps
`include "spc_consts.svh"

module testbench;
	logic        clock;
	logic        sys_rst;
	logic        start;
	logic [7:0]  img_data;
	logic        img_valid;
	logic        img_last;
	logic        img_ready;
	logic        busy;
	logic        load_ok;
	logic        load_fail;
	logic        periph_mode;
	logic        image_loaded;
	logic        user_io_en;
	int          errors;
	int          checks_done;
	logic        bits[$];
	logic [7:0]  img_q[$];
	logic [31:0] sync_w = `SPC_SYNC_WORD;

	// ==========================================================
	// the two ends face each other across the link
	spc_link_if u_spc_link_if ();
	spc_host #(.WAIT_CYC(20)) u_spc_host (.clock(clock), .sys_rst(sys_rst), .link(u_spc_link_if),
		.start(start), .img_data(img_data), .img_valid(img_valid), .img_last(img_last),
		.img_ready(img_ready), .busy(busy), .load_ok(load_ok), .load_fail(load_fail));
	spc_device u_spc_device (.clock(clock), .sys_rst(sys_rst), .link(u_spc_link_if),
		.periph_mode(periph_mode), .image_loaded(image_loaded), .user_io_en(user_io_en));
	spc_link_monitor u_spc_link_monitor (.clock(clock), .sys_rst(sys_rst),
		.config_reset_n(u_spc_link_if.config_reset_n), .rst_oe_n(u_spc_link_if.rst_oe_n),
		.ss_n(u_spc_link_if.ss_n), .sck(u_spc_link_if.sck), .sdi(u_spc_link_if.sdi),
		.config_done(u_spc_link_if.config_done), .sdo(u_spc_link_if.sdo));

	// capture wire bits as the device would, on the rising link clock
	always @(posedge u_spc_link_if.sck)
		if (!u_spc_link_if.ss_n)
			bits.push_back(u_spc_link_if.sdi);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check_val

	task automatic complete_run();
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	// ==========================================================
	// one load of n bytes; valid drops at byte drop (never if drop is 0 or drop >= n)
	task automatic run_load(input int n, input int drop);
		int   idx = 0;
		int   k;
		logic took = 1'b0;
		bits.delete();
		start = 1'b1;
		img_data = img_q[0];
		img_last = 1'b0;
		img_valid = 1'b1;
		@(negedge clock);
		start = 1'b0;
		// valid stays up after the last byte; the tail asks for no byte, so it cannot underrun
		for (k = 0; k < 4000 && !(load_ok === 1'b1 || load_fail === 1'b1); k++) begin
			@(negedge clock);
			if (took && idx < n - 1) begin
				idx++;
				img_data = img_q[idx];
				img_last = (idx == n - 1);
				img_valid = (idx != drop);
			end
			took = (img_ready === 1'b1) && img_valid;
		end
		if (k >= 4000) begin
			errors++;
			complete_run();
		end
		repeat (8) @(negedge clock);
	endtask : run_load

	// full image: done, release, mode and exact bit order on the wire
	task automatic scn_good();
		int         i;
		logic [7:0] b;
		run_load(12, 99);
		check_val(load_ok, 1'b1);
		check_val(busy, 1'b0);
		check_val(u_spc_link_if.config_done, 1'b1);
		check_val(periph_mode, 1'b1);
		check_val(image_loaded, 1'b1);
		check_val(user_io_en, 1'b1);
		check_val(u_spc_link_if.sdo, 1'b0);
		for (i = 0; i < 104; i++) begin
			b = (i < 8) ? `SPC_SHUT_BYTE : img_q[i / 8 - 1];
			check_val(bits[i], b[7 - i % 8]);
		end
	endtask : scn_good

	// valid lost mid image: abort, earlier done cleared by the reset pulse
	task automatic scn_drop();
		run_load(12, 6);
		check_val(load_fail, 1'b1);
		check_val(u_spc_link_if.config_done, 1'b0);
		check_val(user_io_en, 1'b0);
	endtask : scn_drop

	// broken sync word: device never takes the image, host reports failure
	task automatic scn_nosync();
		img_q[1] = 8'h55;
		run_load(12, 99);
		img_q[1] = sync_w[23:16];
		check_val(load_fail, 1'b1);
		check_val(u_spc_link_if.config_done, 1'b0);
	endtask : scn_nosync

	initial begin
		sys_rst = 1'b1;
		start = 1'b0;
		img_data = 8'h00;
		img_valid = 1'b0;
		img_last = 1'b0;
		errors = 0;
		checks_done = 0;
		// plain image body, no boot selection options in it
		img_q = {sync_w[31:24], sync_w[23:16], sync_w[15:8], sync_w[7:0],
			8'h3C, 8'hC3, 8'h5A, 8'hA5, 8'h0F, 8'hF0, 8'h81, 8'h18};
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		scn_good();
		scn_drop();
		scn_nosync();
		// reload after failures repeats the whole sequence
		scn_good();
		complete_run();
	end
endmodule : testbench
